// ===== core/tpcit_cap_if.sv
// Purpose: carrier between the top and a byte capture unit
// Assumes: single clock domain
// Notes:   capture side owns the byte store
`timescale 1ns/10ps
`default_nettype none
interface tpcit_cap_if;
  logic        enable;
  logic        discard;
  logic [23:0] bytes;
  logic [1:0]  count;
  modport top (output enable, output discard, input bytes, input count);
  modport cap (input enable, input discard, output bytes, output count);
endinterface
`default_nettype wire

// ===== core/tpcit_capture.sv
// Purpose: gathers up to three trace bytes of one trace interface
// Assumes: bytes arrive with valid and are taken while enabled
// Notes:   a read discards the bytes and clears the count
`timescale 1ns/10ps
`default_nettype none
module tpcit_capture (
  // clock and reset
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  // trace input
  input  wire logic  at_valid,
  input  wire logic [7:0] at_byte,
  // carrier
  tpcit_cap_if.cap   cap
);
  typedef struct packed {
    logic [23:0] bytes;
    logic [1:0]  count;
  } tpcit_cap_st_t;

  tpcit_cap_st_t s_q;
  tpcit_cap_st_t s_d;

  // store bytes at the next slot until three are held
  always_comb begin
    s_d = s_q;
    if (cap.discard) begin
      s_d.bytes = 24'h000000;
      s_d.count = 2'h0;
    end else if (cap.enable && at_valid && s_q.count < 2'(tpcit_pkg::FIFO_BYTES)) begin
      s_d.bytes[8*s_q.count +: 8] = at_byte;
      s_d.count = s_q.count + 2'h1;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cap.bytes = s_q.bytes;
  assign cap.count = s_q.count;
endmodule
`default_nettype wire

// ===== core/tpcit_pkg.sv
// Purpose: shared constants and types of the trace port control block
// Assumes: 32-bit register port, byte addresses at word offsets
// Notes:   offsets follow the usual layout of such a unit
package tpcit_pkg;
  localparam logic [11:0] OFS_PIN_PROTOCOL = 12'h0f0;
  localparam logic [11:0] OFS_FLUSH_STATUS = 12'h300;
  localparam logic [11:0] OFS_FFCR         = 12'h304;
  localparam logic [11:0] OFS_TRIGGER      = 12'hee8;
  localparam logic [11:0] OFS_FIFO_DATA1   = 12'heec;
  localparam logic [11:0] OFS_ATB_OUT      = 12'hef0;
  localparam logic [11:0] OFS_FIFO_DATA2   = 12'hefc;
  localparam logic [11:0] OFS_ATB_IN       = 12'hef8;
  localparam logic [11:0] OFS_MODE         = 12'hf00;
  localparam logic [11:0] OFS_CLAIM_SET    = 12'hfa0;
  localparam logic [11:0] OFS_CLAIM_CLR    = 12'hfa4;

  localparam int BIT_TRIG_INSERT = 8;
  localparam int BIT_MAN_FLUSH   = 6;
  localparam int BIT_CONT_FMT    = 1;
  localparam int BIT_AF_OVR      = 1;
  localparam int BIT_RDY_OVR     = 0;
  localparam int BIT_VAL2        = 29;
  localparam int LSB_CNT2        = 27;
  localparam int BIT_VAL1        = 26;
  localparam int LSB_CNT1        = 24;
  localparam int CLAIM_W         = 4;
  localparam int FIFO_BYTES      = 3;

  localparam logic [1:0] PROTO_PARALLEL = 2'h0;
  localparam logic [1:0] PROTO_SWO_MAN  = 2'h1;
  localparam logic [1:0] PROTO_SWO_NRZ  = 2'h2;
  localparam logic [3:0] CLAIM_IMPL     = 4'hf;
  // flush drain time in cycles, a plain default
  localparam logic [3:0] FLUSH_CYCLES   = 4'h8;

  typedef enum logic [1:0] {
    TPCIT_NORMAL,
    TPCIT_ITEST,
    TPCIT_IDATA,
    TPCIT_MODE_RSVD
  } tpcit_mode_t;
endpackage

// ===== core/tpcit_top.sv
// Purpose: control, integration test and claim tag registers of a trace port unit
// Assumes: one clock, register port with read data one cycle after the strobe
// Notes:   trace serialisers sit outside; this block only steers them
// Behaviour
// - trigger insertion bit of formatter control always reads one.
// - writing manual flush bit starts a flush; cleared on completion and reset.
// - continuous formatting bit enables or disables continuous formatting.
// - parallel protocol forces formatter on; serial modes restore programmed value.
// - trigger register bit zero returns live trigger input; others zero.
// - fifo data registers report both valid levels and byte counts.
// - first fifo data register shows interface 1 bytes, discarded on read.
// - second fifo data register shows interface 2 bytes, discarded on read.
// - in integration test, drive bit one sets both flush valid outputs.
// - in integration test, drive bit zero sets both ready outputs.
// - input status bit zero returns OR of both valid inputs.
// - input status bit one returns OR of both flush ready inputs.
// - two-bit mode field selects normal, integration test or data test.
// - data test mode disables trace output and exposes input bytes.
// - claim set write one sets a tag; reads show implemented tags.
// - claim clear write one clears a tag; reads show set tags.
// - flush in progress rises on flush start, falls when drained.
// - pin protocol selects parallel, Manchester or NRZ serial output.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
module tpcit_top (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // trigger pin
  input  wire logic        trigger_in,
  // trace interface 1
  input  wire logic        at1_valid,
  input  wire logic [7:0]  at1_byte,
  input  wire logic        af1_ready,
  input  wire logic        at1_ready_norm,
  input  wire logic        af1_valid_norm,
  output logic             at1_ready,
  output logic             af1_valid,
  // trace interface 2
  input  wire logic        at2_valid,
  input  wire logic [7:0]  at2_byte,
  input  wire logic        af2_ready,
  input  wire logic        at2_ready_norm,
  input  wire logic        af2_valid_norm,
  output logic             at2_ready,
  output logic             af2_valid,
  // formatter steering
  output logic             formatter_enable,
  output logic             continuous_format_enable,
  output logic             trace_output_enable,
  output logic [1:0]       pin_protocol_select,
  output logic             flush_request,
  output logic             flush_in_progress
);
  typedef struct packed {
    logic [2:0]          trig_sync;
    logic                trig_lvl;
    logic [1:0]          proto;
    logic                cont_fmt;
    logic                man_flush;
    logic [3:0]          flush_cnt;
    tpcit_pkg::tpcit_mode_t mode;
    logic                af_ovr;
    logic                rdy_ovr;
    logic [3:0]          claim;
    logic [31:0]         rdata;
    logic                at1_ready;
    logic                af1_valid;
    logic                at2_ready;
    logic                af2_valid;
    logic                fmt_en;
    logic                trace_en;
  } tpcit_st_t;

  tpcit_st_t s_q;
  tpcit_st_t s_d;

  tpcit_cap_if cap1 ();
  tpcit_cap_if cap2 ();

  // address compare used by every decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  // byte capture, one per trace interface
  tpcit_capture u_cap1 (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .at_valid (at1_valid),
    .at_byte  (at1_byte),
    .cap      (cap1.cap)
  );

  tpcit_capture u_cap2 (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .at_valid (at2_valid),
    .at_byte  (at2_byte),
    .cap      (cap2.cap)
  );

  // capture runs in data test mode; a read of its register discards
  assign cap1.enable  = (s_q.mode == tpcit_pkg::TPCIT_IDATA);
  assign cap2.enable  = (s_q.mode == tpcit_pkg::TPCIT_IDATA);
  assign cap1.discard = reg_rd && hit(reg_addr, tpcit_pkg::OFS_FIFO_DATA1);
  assign cap2.discard = reg_rd && hit(reg_addr, tpcit_pkg::OFS_FIFO_DATA2);

  // next state: trigger sync, register writes, flush, read mux, outputs
  always_comb begin
    logic [31:0] fifo_stat;
    logic        fmt_eff;
    logic        itest;
    fifo_stat = 32'h00000000;
    fmt_eff   = 1'b0;
    itest     = 1'b0;
    s_d = s_q;
    s_d.trig_sync = {s_q.trig_sync[1:0], trigger_in};
    // pin level only moves once the last two stages agree, so a late edge cannot glitch it
    if (s_q.trig_sync[2] == s_q.trig_sync[1]) begin
      s_d.trig_lvl = s_q.trig_sync[2];
    end

    // register writes
    if (reg_wr) begin
      if (hit(reg_addr, tpcit_pkg::OFS_PIN_PROTOCOL)) begin
        s_d.proto = reg_wdata[1:0];
      end
      if (hit(reg_addr, tpcit_pkg::OFS_FFCR)) begin
        s_d.cont_fmt = reg_wdata[tpcit_pkg::BIT_CONT_FMT];
        if (reg_wdata[tpcit_pkg::BIT_MAN_FLUSH] && !s_q.man_flush) begin
          s_d.man_flush = 1'b1;
          s_d.flush_cnt = tpcit_pkg::FLUSH_CYCLES;
        end
      end
      if (hit(reg_addr, tpcit_pkg::OFS_ATB_OUT)) begin
        s_d.af_ovr  = reg_wdata[tpcit_pkg::BIT_AF_OVR];
        s_d.rdy_ovr = reg_wdata[tpcit_pkg::BIT_RDY_OVR];
      end
      if (hit(reg_addr, tpcit_pkg::OFS_MODE)) begin
        s_d.mode = tpcit_pkg::tpcit_mode_t'(reg_wdata[1:0]);
      end
      if (hit(reg_addr, tpcit_pkg::OFS_CLAIM_SET)) begin
        s_d.claim = s_q.claim | reg_wdata[tpcit_pkg::CLAIM_W-1:0];
      end
      if (hit(reg_addr, tpcit_pkg::OFS_CLAIM_CLR)) begin
        s_d.claim = s_q.claim & ~reg_wdata[tpcit_pkg::CLAIM_W-1:0];
      end
    end

    // flush drains for a fixed time, then both flags drop
    if (s_q.man_flush) begin
      if (s_q.flush_cnt == 4'h1) begin
        s_d.man_flush = 1'b0;
        s_d.flush_cnt = 4'h0;
      end else begin
        s_d.flush_cnt = s_q.flush_cnt - 4'h1;
      end
    end

    // status fields shared by both fifo data registers
    fifo_stat[tpcit_pkg::BIT_VAL2] = at2_valid;
    fifo_stat[tpcit_pkg::LSB_CNT2 +: 2] = cap2.count;
    fifo_stat[tpcit_pkg::BIT_VAL1] = at1_valid;
    fifo_stat[tpcit_pkg::LSB_CNT1 +: 2] = cap1.count;

    // read data, one cycle after the strobe; unmapped reads zero
    s_d.rdata = 32'h00000000;
    if (reg_rd) begin
      unique case (1'b1)
        hit(reg_addr, tpcit_pkg::OFS_PIN_PROTOCOL): s_d.rdata[1:0] = s_q.proto;
        hit(reg_addr, tpcit_pkg::OFS_FLUSH_STATUS): s_d.rdata[0] = s_q.man_flush;
        hit(reg_addr, tpcit_pkg::OFS_FFCR): begin
          s_d.rdata[tpcit_pkg::BIT_TRIG_INSERT] = 1'b1;
          s_d.rdata[tpcit_pkg::BIT_MAN_FLUSH]   = s_q.man_flush;
          s_d.rdata[tpcit_pkg::BIT_CONT_FMT]    = s_q.cont_fmt;
        end
        hit(reg_addr, tpcit_pkg::OFS_TRIGGER): s_d.rdata[0] = s_q.trig_lvl;
        hit(reg_addr, tpcit_pkg::OFS_FIFO_DATA1): s_d.rdata = fifo_stat | {8'h00, cap1.bytes};
        hit(reg_addr, tpcit_pkg::OFS_FIFO_DATA2): s_d.rdata = fifo_stat | {8'h00, cap2.bytes};
        hit(reg_addr, tpcit_pkg::OFS_ATB_IN): begin
          s_d.rdata[0] = at1_valid | at2_valid;
          s_d.rdata[1] = af1_ready | af2_ready;
        end
        hit(reg_addr, tpcit_pkg::OFS_MODE): s_d.rdata[1:0] = s_q.mode;
        hit(reg_addr, tpcit_pkg::OFS_CLAIM_SET): s_d.rdata[3:0] = tpcit_pkg::CLAIM_IMPL;
        hit(reg_addr, tpcit_pkg::OFS_CLAIM_CLR): s_d.rdata[3:0] = s_q.claim;
        default: s_d.rdata = 32'h00000000;
      endcase
    end

    // output steering
    fmt_eff = (s_q.proto == tpcit_pkg::PROTO_PARALLEL) | s_q.cont_fmt;
    itest   = (s_q.mode == tpcit_pkg::TPCIT_ITEST);
    s_d.fmt_en    = fmt_eff;
    s_d.trace_en  = (s_q.mode != tpcit_pkg::TPCIT_IDATA);
    s_d.at1_ready = itest ? s_q.rdy_ovr : at1_ready_norm;
    s_d.at2_ready = itest ? s_q.rdy_ovr : at2_ready_norm;
    s_d.af1_valid = itest ? s_q.af_ovr : af1_valid_norm;
    s_d.af2_valid = itest ? s_q.af_ovr : af2_valid_norm;
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign reg_rdata                = s_q.rdata;
  assign at1_ready                = s_q.at1_ready;
  assign af1_valid                = s_q.af1_valid;
  assign at2_ready                = s_q.at2_ready;
  assign af2_valid                = s_q.af2_valid;
  assign formatter_enable         = s_q.fmt_en;
  assign continuous_format_enable = s_q.cont_fmt;
  assign trace_output_enable      = s_q.trace_en;
  assign pin_protocol_select      = s_q.proto;
  assign flush_request            = s_q.man_flush;
  assign flush_in_progress        = s_q.man_flush;
endmodule
`default_nettype wire

// ===== dv/tpcit_atb_src.sv
// Purpose: trace source that sends short byte bursts
// Assumes: one byte per cycle while valid
// Notes:   idle byte lines toggle so stale data never looks valid
`timescale 1ns/10ps
`default_nettype none
module tpcit_atb_src (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // burst request
  input  wire logic       start,
  input  wire logic [1:0] len,
  input  wire logic [7:0] base,
  // trace output
  output logic            at_valid,
  output logic [7:0]      at_byte
);
  logic [1:0] left_q;
  assign at_valid = (left_q != 2'h0);
  // counts the burst down, inverts the byte when idle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      left_q  <= 2'h0;
      at_byte <= 8'h0;
    end else if (start) begin
      left_q  <= len;
      at_byte <= base;
    end else if (left_q > 2'h1) begin
      left_q  <= left_q - 2'h1;
      at_byte <= at_byte + 8'h1;
    end else begin
      left_q  <= 2'h0;
      at_byte <= ~at_byte;
    end
  end
endmodule
`default_nettype wire

// ===== dv/tpcit_monitor.sv
// Purpose: port checker of the trace port control block
// Assumes: one clock, read data one cycle after the strobe
// Notes:   bound into every instance of the top
`timescale 1ns/10ps
`default_nettype none
module tpcit_monitor (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // trace interfaces
  input wire logic        at1_valid,
  input wire logic        at2_valid,
  input wire logic        af1_ready,
  input wire logic        af2_ready,
  // formatter steering
  input wire logic        formatter_enable,
  input wire logic        continuous_format_enable,
  input wire logic [1:0]  pin_protocol_select,
  input wire logic        flush_request,
  input wire logic        flush_in_progress
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic        rd_q;
  logic [11:0] ra_q;
  // remembers the read taken at the last edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      ra_q <= 12'h0;
    end else begin
      rd_q <= reg_rd;
      ra_q <= reg_addr;
    end
  end
  property p_trig_ins; rd_q && ra_q == tpcit_pkg::OFS_FFCR |-> reg_rdata[8]; endproperty
  a_trig_ins: assert property (p_trig_ins) else $error("insert bit low");
  property p_trig_rd; rd_q && ra_q == tpcit_pkg::OFS_TRIGGER |-> reg_rdata[31:1] == 31'h0;
  endproperty
  a_trig_rd: assert property (p_trig_rd) else $error("trigger upper bits set");
  property p_claim_rd;
    rd_q && ra_q == tpcit_pkg::OFS_CLAIM_SET |-> reg_rdata == {28'h0, tpcit_pkg::CLAIM_IMPL};
  endproperty
  a_claim_rd: assert property (p_claim_rd) else $error("claim set read");
  property p_fmt_on;
    $past(rst_n) && pin_protocol_select == 2'h0 && $past(pin_protocol_select) == 2'h0
      |-> formatter_enable;
  endproperty
  a_fmt_on: assert property (p_fmt_on) else $error("parallel without formatter");
  property p_fmt_cont; $past(continuous_format_enable) && continuous_format_enable
    |-> formatter_enable; endproperty
  a_fmt_cont: assert property (p_fmt_cont) else $error("continuous without formatter");
  property p_fl_start; reg_wr && reg_addr == tpcit_pkg::OFS_FFCR && reg_wdata[6]
    && !flush_request |=> flush_request; endproperty
  a_fl_start: assert property (p_fl_start) else $error("flush not started");
  property p_fl_len; $rose(flush_request) |-> flush_request [*8] ##1 !flush_request;
  endproperty
  a_fl_len: assert property (p_fl_len) else $error("flush length");
  property p_fl_prog; flush_in_progress == flush_request; endproperty
  a_fl_prog: assert property (p_fl_prog) else $error("flush status");
  property p_in_stat; rd_q && ra_q == tpcit_pkg::OFS_ATB_IN |-> reg_rdata ==
    {30'h0, $past(af1_ready | af2_ready), $past(at1_valid | at2_valid)}; endproperty
  a_in_stat: assert property (p_in_stat) else $error("input status");
  property p_fifo_val;
    rd_q && (ra_q == tpcit_pkg::OFS_FIFO_DATA1 || ra_q == tpcit_pkg::OFS_FIFO_DATA2)
      |-> reg_rdata[29] == $past(at2_valid) && reg_rdata[26] == $past(at1_valid);
  endproperty
  a_fifo_val: assert property (p_fifo_val) else $error("fifo valid bits");
  // main scenarios
  c_flush: cover property ($rose(flush_request));
  c_fifo: cover property (rd_q && ra_q == tpcit_pkg::OFS_FIFO_DATA1 && reg_rdata[25:24] == 2'h3);
  c_nrz: cover property (pin_protocol_select == 2'h2 && !formatter_enable);
endmodule
bind tpcit_top tpcit_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .at1_valid(at1_valid), .at2_valid(at2_valid), .af1_ready(af1_ready),
  .af2_ready(af2_ready), .formatter_enable(formatter_enable),
  .continuous_format_enable(continuous_format_enable),
  .pin_protocol_select(pin_protocol_select), .flush_request(flush_request),
  .flush_in_progress(flush_in_progress));
`default_nettype wire

// ===== dv/tpcit_tb_top.sv
// Purpose: register level test of the trace port control block
// Assumes: read data sampled just after the answer edge
// Notes:   bytes come from two burst sources
`timescale 1ns/10ps
`default_nettype none
module tpcit_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, d;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, trigger_in = 1'b0;
  logic [1:0]  af_rdy = 2'h0, go = 2'h0, v, pps;
  logic [3:0]  nrm = 4'ha, pins;
  logic [7:0]  b1, b2;
  logic        fe, cfe, toe, frq, fip;
  int          err_count = 0, n_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  tpcit_atb_src u_s1 (.clk_sys(clk_sys), .rst_n(rst_n), .start(go[0]), .len(2'h3),
    .base(8'ha0), .at_valid(v[0]), .at_byte(b1));
  tpcit_atb_src u_s2 (.clk_sys(clk_sys), .rst_n(rst_n), .start(go[1]), .len(2'h2),
    .base(8'hb0), .at_valid(v[1]), .at_byte(b2));
  tpcit_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_in(trigger_in),
    .at1_valid(v[0]), .at1_byte(b1), .af1_ready(af_rdy[0]), .at1_ready_norm(nrm[0]),
    .af1_valid_norm(nrm[2]), .at1_ready(pins[0]), .af1_valid(pins[2]),
    .at2_valid(v[1]), .at2_byte(b2), .af2_ready(af_rdy[1]), .at2_ready_norm(nrm[1]),
    .af2_valid_norm(nrm[3]), .at2_ready(pins[1]), .af2_valid(pins[3]),
    .formatter_enable(fe), .continuous_format_enable(cfe), .trace_output_enable(toe),
    .pin_protocol_select(pps), .flush_request(frq), .flush_in_progress(fip));
  // one-cycle bus write and read
  task automatic wr(input logic [11:0] a, input logic [31:0] w);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(e & m, d & m);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #(25 * 4000);
    err_count++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc(tpcit_pkg::OFS_FFCR, 32'h100, '1);
    rdc(tpcit_pkg::OFS_CLAIM_CLR, 32'h0, '1);
    rdc(12'h004, 32'h0, '1);
    chk(32'h3, {30'h0, fe, toe});
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 2; c++) begin
        wr(tpcit_pkg::OFS_FFCR, 32'(c) << 1);
        wr(tpcit_pkg::OFS_PIN_PROTOCOL, 32'(p));
        settle();
        chk(32'(p == 0 || c == 1), 32'(fe));
        chk(32'(c), 32'(cfe));
        chk(32'(p), 32'(pps));
        rdc(tpcit_pkg::OFS_FFCR, 32'h100 | 32'(c) << 1, p == 0 ? 32'hfffffffd : '1);
        rdc(tpcit_pkg::OFS_PIN_PROTOCOL, 32'(p), '1);
      end
    end
    wr(tpcit_pkg::OFS_FFCR, 32'h40);
    rdc(tpcit_pkg::OFS_FFCR, 32'h140, 32'h140);
    rdc(tpcit_pkg::OFS_FLUSH_STATUS, 32'h1, '1);
    repeat (8) @(posedge clk_sys);
    rdc(tpcit_pkg::OFS_FFCR, 32'h100, 32'h140);
    rdc(tpcit_pkg::OFS_FLUSH_STATUS, 32'h0, '1);
    for (int t = 1; t >= 0; t--) begin
      @(posedge clk_sys);
      trigger_in <= t[0];
      repeat (5) @(posedge clk_sys);
      rdc(tpcit_pkg::OFS_TRIGGER, 32'(t), '1);
    end
    wr(tpcit_pkg::OFS_MODE, 32'h1);
    for (int o = 0; o < 4; o++) begin
      wr(tpcit_pkg::OFS_ATB_OUT, 32'(o));
      settle();
      chk(32'({o[1], o[1], o[0], o[0]}), 32'(pins));
    end
    rdc(tpcit_pkg::OFS_ATB_OUT, 32'h0, '1);
    wr(tpcit_pkg::OFS_MODE, 32'h0);
    settle();
    chk(32'ha, 32'(pins));
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      af_rdy <= s[1:0];
      rdc(tpcit_pkg::OFS_ATB_IN, 32'(s != 0) << 1, '1);
    end
    wr(tpcit_pkg::OFS_MODE, 32'h2);
    settle();
    chk(32'h0, 32'(toe));
    @(posedge clk_sys);
    go <= 2'h3;
    @(posedge clk_sys);
    go <= 2'h0;
    settle();
    rdc(tpcit_pkg::OFS_FIFO_DATA1, 32'h13a2a1a0, '1);
    rdc(tpcit_pkg::OFS_FIFO_DATA1, 32'h10000000, 32'hff000000);
    rdc(tpcit_pkg::OFS_FIFO_DATA2, 32'h1000b1b0, 32'hff00ffff);
    rdc(tpcit_pkg::OFS_FIFO_DATA2, 32'h0, 32'hff000000);
    wr(tpcit_pkg::OFS_CLAIM_SET, 32'h5);
    wr(tpcit_pkg::OFS_CLAIM_SET, 32'h2);
    rdc(tpcit_pkg::OFS_CLAIM_CLR, 32'h7, '1);
    wr(tpcit_pkg::OFS_CLAIM_CLR, 32'h9);
    rdc(tpcit_pkg::OFS_CLAIM_CLR, 32'h6, '1);
    rdc(tpcit_pkg::OFS_CLAIM_SET, 32'hf, '1);
    wr(tpcit_pkg::OFS_MODE, 32'h3);
    rdc(tpcit_pkg::OFS_MODE, 32'h3, '1);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc(tpcit_pkg::OFS_CLAIM_CLR, 32'h0, '1);
    rdc(tpcit_pkg::OFS_MODE, 32'h0, '1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
